// file: shared/eals_pkg.sv
/*
  Constants, types and the instruction decoder for the effective-address,
  load and store block of a 16-bit word-addressed processor.
  Assumes a single 100 MHz clock and a core memory of up to 65,536 words.

  // Operation
  // - instructions are one or two words; first word from lower address
  // - long modes 0..3: immediate, direct, indirect, indirect pre-indexed
  // - long modes 4..7: field plus A, pointer plus X, plus X, plus P
  // - pointer word with sign set causes another level of indirection
  // - relative addressing uses P already pointing past the instruction
  // - short modes 00,01,10: direct, plus X, indirect over 0..1023
  // - short mode 11 adds signed displacement up to 511 to P
  // - io without memory is one word; with memory a second address word
  // - io modes 0..3: following word, or A, B, X directly
  // - io modes 4..7: direct, plus X, indirect, indirect then plus X
  // - single fixed point: sign plus 15 bits, two's complement
  // - double fixed point: sign plus 30 bits, second word sign zero
  // - single float: 22-bit mantissa, 8-bit exponent biased by 200 octal
  // - double float: 45-bit mantissa, 15-bit exponent, words 2,3 sign 0
  // - loads fill A, B or X; 3 cycles long, 2 cycles short
  // - stores write A, B or X to memory; 3 cycles long, 2 short
  // - double load: two words into A then B, in 4 cycles
  // - double store: A then B into two successive words
  // - effective-address load resolves all levels and writes X
  // - unimplemented memory: writes do nothing, reads give zero
*/
package eals_pkg;
    typedef logic [15:0] eals_word_t;

    localparam int SOP_HI   = 15;
    localparam int SOP_LO   = 12;
    localparam int SMODE_HI = 11;
    localparam int SMODE_LO = 10;
    localparam int SFLD_HI  = 9;
    localparam int SIGN_BIT = 15;
    localparam int PTR_HI   = 14;
    localparam int LSUB_HI  = 11;
    localparam int LSUB_LO  = 6;
    localparam int IODEV_HI = 5;
    localparam int IODEV_LO = 3;
    localparam int LMODE_HI = 2;
    localparam int BANK_HI  = 15;
    localparam int BANK_LO  = 12;

    // data formats: the block moves them as whole words, low-word sign kept
    localparam int DFIX_BITS  = 30;
    localparam int FLT_MANT   = 22;
    localparam logic [7:0] FLT_BIAS = 8'h80;
    localparam int DFLT_MANT  = 45;
    localparam int DFLT_EXP   = 15;

    localparam logic [3:0] SOP_LONG = 4'h0;
    localparam logic [3:0] SOP_LD_A  = 4'h1;
    localparam logic [3:0] SOP_LD_B  = 4'h2;
    localparam logic [3:0] SOP_LD_X  = 4'h3;
    localparam logic [3:0] SOP_ST_A  = 4'h4;
    localparam logic [3:0] SOP_ST_B  = 4'h5;
    localparam logic [3:0] SOP_ST_X  = 4'h6;
    localparam logic [5:0] LSUB_LD_A = 6'h01;
    localparam logic [5:0] LSUB_LD_B = 6'h02;
    localparam logic [5:0] LSUB_LD_X = 6'h03;
    localparam logic [5:0] LSUB_ST_A = 6'h04;
    localparam logic [5:0] LSUB_ST_B = 6'h05;
    localparam logic [5:0] LSUB_ST_X = 6'h06;
    localparam logic [5:0] LSUB_DBL_LD = 6'h07;
    localparam logic [5:0] LSUB_DBL_ST = 6'h08;
    localparam logic [5:0] LSUB_EA_LD  = 6'h09;
    localparam logic [5:0] LSUB_IO  = 6'h0a;

    localparam logic [15:0] P_RESET = 16'h0000;
    localparam int LONG_CYCLES  = 3;
    localparam int SHORT_CYCLES = 2;
    localparam int DBL_LD_CYCLES = 4;

    typedef enum logic [3:0] {
        OP_NOP, OP_LD_A, OP_LD_B, OP_LD_X, OP_ST_A, OP_ST_B, OP_ST_X,
        OP_DBL_LD, OP_DBL_ST, OP_EA_LD, OP_IO
    } eals_op_t;
    typedef enum logic [1:0] {FORM_SHORT, FORM_LONG, FORM_IO} eals_form_t;
    typedef enum logic [1:0] {K_EA, K_IND, K_IMM, K_REG} eals_kind_t;
    typedef enum logic [2:0] {
        S_FETCH = 3'h0, S_WORD2 = 3'h1, S_IND = 3'h3, S_OPER = 3'h2,
        S_OPER2 = 3'h6, S_BOOT = 3'h4
    } eals_state_t;

    typedef struct packed {
        eals_op_t   op;
        eals_form_t form;
        logic [2:0] mode;
    } eals_dec_t;

    function automatic eals_dec_t eals_decode(eals_word_t w);
        eals_dec_t d;
        d = '{op: OP_NOP, form: FORM_SHORT, mode: {1'b0, w[SMODE_HI:SMODE_LO]}};
        case (w[SOP_HI:SOP_LO])
            SOP_LONG: begin
                d.form = FORM_LONG;
                d.mode = w[LMODE_HI:0];
                case (w[LSUB_HI:LSUB_LO])
                    LSUB_LD_A: d.op = OP_LD_A;
                    LSUB_LD_B: d.op = OP_LD_B;
                    LSUB_LD_X: d.op = OP_LD_X;
                    LSUB_ST_A: d.op = OP_ST_A;
                    LSUB_ST_B: d.op = OP_ST_B;
                    LSUB_ST_X: d.op = OP_ST_X;
                    LSUB_DBL_LD: d.op = OP_DBL_LD;
                    LSUB_DBL_ST: d.op = OP_DBL_ST;
                    LSUB_EA_LD: d.op = OP_EA_LD;
                    LSUB_IO: begin
                        d.op = OP_IO;
                        d.form = FORM_IO;
                    end
                    default: d.op = OP_NOP;
                endcase
            end
            SOP_LD_A: d.op = OP_LD_A;
            SOP_LD_B: d.op = OP_LD_B;
            SOP_LD_X: d.op = OP_LD_X;
            SOP_ST_A: d.op = OP_ST_A;
            SOP_ST_B: d.op = OP_ST_B;
            SOP_ST_X: d.op = OP_ST_X;
            default: d.op = OP_NOP;
        endcase
        return d;
    endfunction
endpackage

// file: shared/eals_efa_if.sv
/*
  Carrier between the sequencer and the effective-address calculator.
  Assumes both ends sit on the same clock; the calculator is combinational.
*/
`timescale 1ns/100ps
`default_nettype none
interface eals_efa_if;
    import eals_pkg::*;
    eals_form_t form;
    logic [2:0] mode;
    eals_word_t field;
    eals_word_t reg_a;
    eals_word_t reg_b;
    eals_word_t reg_x;
    eals_word_t reg_p;
    eals_kind_t kind;
    eals_word_t ea;
    eals_word_t ptr;
    logic       post_x;
    modport seq  (output form, mode, field, reg_a, reg_b, reg_x, reg_p,
                  input kind, ea, ptr, post_x);
    modport calc (input form, mode, field, reg_a, reg_b, reg_x, reg_p,
                  output kind, ea, ptr, post_x);
endinterface
`default_nettype wire

// file: hdl/eals_efa_calc.sv
/*
  Effective-address calculator for short, long and io forms.
  Assumes reg_p already points past the instruction being executed.
*/
`timescale 1ns/100ps
`default_nettype none
module eals_efa_calc
    import eals_pkg::*;
(
    eals_efa_if.calc ef
);
    eals_word_t sfld;
    eals_word_t srel;

    assign sfld = {6'h00, ef.field[SFLD_HI:0]};
    assign srel = {{6{ef.field[SFLD_HI]}}, ef.field[SFLD_HI:0]};

    always_comb begin
        ef.kind   = K_EA;
        ef.ea     = ef.field;
        ef.ptr    = ef.field;
        ef.post_x = 1'b0;
        case (ef.form)
            FORM_SHORT: begin
                case (ef.mode[1:0])
                    2'h0: ef.ea = sfld;
                    2'h1: ef.ea = sfld + ef.reg_x;
                    2'h2: begin
                        ef.kind = K_IND;
                        ef.ptr  = sfld;
                    end
                    default: ef.ea = ef.reg_p + srel;
                endcase
            end
            FORM_LONG: begin
                case (ef.mode)
                    3'h0: ef.kind = K_IMM;
                    3'h1: ef.ea = ef.field;
                    3'h2: ef.kind = K_IND;
                    3'h3: begin
                        ef.kind = K_IND;
                        ef.ptr  = ef.field + ef.reg_x;
                    end
                    3'h4: ef.ea = ef.field + ef.reg_a;
                    3'h5: begin
                        ef.kind   = K_IND;
                        ef.post_x = 1'b1;
                    end
                    3'h6: ef.ea = ef.field + ef.reg_x;
                    default: ef.ea = ef.field + ef.reg_p;
                endcase
            end
            default: begin
                case (ef.mode)
                    3'h0: ef.kind = K_IMM;
                    3'h1: begin
                        ef.kind = K_REG;
                        ef.ea   = ef.reg_a;
                    end
                    3'h2: begin
                        ef.kind = K_REG;
                        ef.ea   = ef.reg_b;
                    end
                    3'h3: begin
                        ef.kind = K_REG;
                        ef.ea   = ef.reg_x;
                    end
                    3'h4: ef.ea = ef.field;
                    3'h5: ef.ea = ef.field + ef.reg_x;
                    3'h6: ef.kind = K_IND;
                    default: begin
                        ef.kind   = K_IND;
                        ef.post_x = 1'b1;
                    end
                endcase
            end
        endcase
    end
endmodule
`default_nettype wire

// file: hdl/eals_core.sv
/*
  Sequencer for load, store, double-word, effective-address and io
  memory-reference instructions.  One state is one memory cycle.
  Assumes a core memory on mclk whose reads are combinational: a read strobed in one cycle
  presents its word on mem_rdata in that same cycle.  mem_banks is a static
  strap giving how many 4096-word banks are fitted.
*/
`timescale 1ns/100ps
`default_nettype none
module eals_core
    import eals_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [15:0] mem_rdata,
    input  wire logic [4:0]  mem_banks,
    output var  logic        mem_rd,
    output var  logic        mem_wr,
    output var  logic [15:0] mem_addr,
    output var  logic [15:0] mem_wdata,
    output var  logic        io_stb,
    output var  logic [2:0]  io_dev,
    output var  logic [15:0] io_data,
    output var  logic [15:0] reg_a,
    output var  logic [15:0] reg_b,
    output var  logic [15:0] reg_x,
    output var  logic [15:0] reg_p
);
    typedef struct packed {
        eals_state_t st;
        eals_op_t    op;
        eals_form_t  form;
        logic [2:0]  mode;
        eals_word_t  ea;
        eals_word_t  a;
        eals_word_t  b;
        eals_word_t  x;
        eals_word_t  p;
        logic        post_x;
        logic        rd;
        logic        wr;
        logic        hit;
        eals_word_t  addr;
        eals_word_t  wdata;
        logic        iostb;
        logic [2:0]  iodev;
        eals_word_t  iodata;
        logic [4:0]  bank_s1;
        logic [4:0]  bank_s2;
        logic [1:0]  boot;
    } eals_core_t;

    localparam eals_core_t CORE_RESET = '{
        st: S_BOOT, op: OP_NOP, form: FORM_SHORT, mode: 3'h0,
        ea: 16'h0000, a: 16'h0000, b: 16'h0000, x: 16'h0000, p: P_RESET,
        post_x: 1'b0, rd: 1'b0, wr: 1'b0, hit: 1'b0, addr: 16'h0000,
        wdata: 16'h0000, iostb: 1'b0, iodev: 3'h0, iodata: 16'h0000,
        bank_s1: 5'h00, bank_s2: 5'h00, boot: 2'h0};

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    eals_core_t  s_q;
    eals_core_t  n;
    eals_word_t  rdat;
    eals_dec_t   dec;
    logic        need_w2;
    logic        is_read;
    logic        go_fetch;
    logic        do_res;
    logic        res_imm;
    logic        take_op;
    eals_word_t  res_ea;
    eals_efa_if  efa ();

    eals_efa_calc u_efa (
        .ef (efa.calc)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // a word from an absent bank reads as zero
    assign rdat = s_q.hit ? mem_rdata : 16'h0000;
    assign dec  = eals_decode(rdat);
    assign need_w2 = (dec.form == FORM_LONG) ||
                     ((dec.form == FORM_IO) &&
                      ((dec.mode == 3'h0) || dec.mode[LMODE_HI]));
    assign is_read = (s_q.op == OP_LD_A) || (s_q.op == OP_LD_B) ||
                     (s_q.op == OP_LD_X) || (s_q.op == OP_DBL_LD) ||
                     (s_q.op == OP_IO);

    assign efa.form  = (s_q.st == S_FETCH) ? dec.form : s_q.form;
    assign efa.mode  = (s_q.st == S_FETCH) ? dec.mode : s_q.mode;
    assign efa.field = rdat;
    assign efa.reg_a = s_q.a;
    assign efa.reg_b = s_q.b;
    assign efa.reg_x = s_q.x;
    assign efa.reg_p = s_q.p;

    always_comb begin
        n          = s_q;
        n.rd       = 1'b0;
        n.wr       = 1'b0;
        n.iostb    = 1'b0;
        n.bank_s1  = mem_banks;
        n.bank_s2  = s_q.bank_s1;
        go_fetch   = 1'b0;
        do_res     = 1'b0;
        res_imm    = 1'b0;
        take_op    = 1'b0;
        res_ea     = 16'h0000;
        case (s_q.st)
            S_BOOT: begin
                // first fetch waits until the bank strap is through both flops
                n.boot   = {s_q.boot[0], 1'b1};
                go_fetch = s_q.boot[1];
            end
            S_FETCH: begin
                n.op   = dec.op;
                n.form = dec.form;
                n.mode = dec.mode;
                n.iodev = rdat[IODEV_HI:IODEV_LO];
                if (dec.op == OP_NOP) begin
                    go_fetch = 1'b1;
                end else if (need_w2) begin
                    // second word sits at the next higher address
                    n.st   = S_WORD2;
                    n.rd   = 1'b1;
                    n.addr = s_q.p;
                    n.p    = s_q.p + 16'h0001;
                end else if (efa.kind == K_REG) begin
                    n.iostb  = 1'b1;
                    n.iodata = efa.ea;
                    go_fetch = 1'b1;
                end else if (efa.kind == K_IND) begin
                    n.st     = S_IND;
                    n.rd     = 1'b1;
                    n.addr   = efa.ptr;
                    n.post_x = efa.post_x;
                end else begin
                    do_res = 1'b1;
                    res_ea = efa.ea;
                end
            end
            S_WORD2: begin
                if (efa.kind == K_IND) begin
                    n.st     = S_IND;
                    n.rd     = 1'b1;
                    n.addr   = efa.ptr;
                    n.post_x = efa.post_x;
                end else if (efa.kind == K_IMM) begin
                    // immediate operand is the second word itself
                    do_res  = 1'b1;
                    res_imm = 1'b1;
                    res_ea  = s_q.p - 16'h0001;
                end else begin
                    do_res = 1'b1;
                    res_ea = efa.ea;
                end
            end
            S_IND: begin
                if (rdat[SIGN_BIT]) begin
                    // one more level; the sign bit is never part of an address
                    n.rd   = 1'b1;
                    n.addr = {1'b0, rdat[PTR_HI:0]};
                end else begin
                    do_res = 1'b1;
                    res_ea = {1'b0, rdat[PTR_HI:0]} +
                             (s_q.post_x ? s_q.x : 16'h0000);
                end
            end
            S_OPER: begin
                if (s_q.op == OP_DBL_ST) begin
                    n.st    = S_OPER2;
                    n.wr    = 1'b1;
                    n.addr  = s_q.ea + 16'h0001;
                    n.wdata = s_q.b;
                end else if (is_read) begin
                    take_op = 1'b1;
                end else begin
                    go_fetch = 1'b1;
                end
            end
            S_OPER2: begin
                if (s_q.op == OP_DBL_LD) begin
                    n.b = rdat;
                end
                go_fetch = 1'b1;
            end
            default: go_fetch = 1'b1;
        endcase

        if (do_res) begin
            n.ea = res_ea;
            case (n.op)
                OP_EA_LD: begin
                    n.x      = res_imm ? rdat : res_ea;
                    go_fetch = 1'b1;
                end
                OP_ST_A, OP_ST_B, OP_ST_X, OP_DBL_ST: begin
                    n.st   = S_OPER;
                    n.wr   = 1'b1;
                    n.addr = res_ea;
                    n.wdata = (n.op == OP_ST_B) ? s_q.b :
                              (n.op == OP_ST_X) ? s_q.x : s_q.a;
                end
                default: begin
                    if (res_imm) begin
                        take_op = 1'b1;
                    end else begin
                        n.st   = S_OPER;
                        n.rd   = 1'b1;
                        n.addr = res_ea;
                    end
                end
            endcase
        end

        if (take_op) begin
            case (n.op)
                OP_LD_A: n.a = rdat;
                OP_LD_B: n.b = rdat;
                OP_LD_X: n.x = rdat;
                OP_DBL_LD: begin
                    n.a    = rdat;
                    n.st   = S_OPER2;
                    n.rd   = 1'b1;
                    n.addr = n.ea + 16'h0001;
                end
                OP_IO: begin
                    n.iostb  = 1'b1;
                    n.iodata = rdat;
                end
                default: n.iostb = 1'b0;
            endcase
            go_fetch = (n.op != OP_DBL_LD);
        end

        if (go_fetch) begin
            n.st   = S_FETCH;
            n.rd   = 1'b1;
            n.addr = n.p;
            n.p    = n.p + 16'h0001;
        end

        // an absent bank swallows the write and answers reads with zero
        n.hit = ({1'b0, n.addr[BANK_HI:BANK_LO]} < s_q.bank_s2);
        n.wr  = n.wr & n.hit;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= CORE_RESET;
        end else begin
            s_q <= n;
        end
    end

    assign mem_rd    = s_q.rd;
    assign mem_wr    = s_q.wr;
    assign mem_addr  = s_q.addr;
    assign mem_wdata = s_q.wdata;
    assign io_stb    = s_q.iostb;
    assign io_dev    = s_q.iodev;
    assign io_data   = s_q.iodata;
    assign reg_a     = s_q.a;
    assign reg_b     = s_q.b;
    assign reg_x     = s_q.x;
    assign reg_p     = s_q.p;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence short_ld_s;
        s_q.st == S_FETCH && dec.form == FORM_SHORT && dec.op == OP_LD_A &&
        dec.mode[1:0] != 2'h2;
    endsequence
    sequence long_ld_s;
        s_q.st == S_FETCH && dec.op == OP_LD_B && dec.form == FORM_LONG &&
        (dec.mode == 3'h1 || dec.mode == 3'h6 || dec.mode == 3'h7);
    endsequence
    sequence short_done_s;
        s_q.st == S_OPER ##1 s_q.st == S_FETCH;
    endsequence
    sequence long_done_s;
        s_q.st == S_WORD2 ##1 s_q.st == S_OPER ##1 s_q.st == S_FETCH;
    endsequence

    word2_addr_a: assert property (s_q.st == S_WORD2 |->
        s_q.addr == $past(s_q.addr) + 16'h0001)
        else $error("second word not at next address");
    absent_write_a: assert property (s_q.wr |-> s_q.hit)
        else $error("write issued to absent bank");
    chain_ptr_a: assert property (s_q.st == S_IND && rdat[SIGN_BIT] |=>
        s_q.st == S_IND && s_q.rd &&
        s_q.addr == {1'b0, $past(rdat[PTR_HI:0])})
        else $error("indirect chain not followed");
    short_load_a: assert property (short_ld_s |=> short_done_s)
        else $error("short load cycle count wrong");
    long_load_a: assert property (long_ld_s |=> long_done_s)
        else $error("long load cycle count wrong");
    store_data_a: assert property (s_q.st == S_OPER && s_q.op == OP_ST_X
        |-> s_q.wdata == s_q.x && s_q.addr == s_q.ea)
        else $error("store data or address wrong");
    dbl_ld_order_a: assert property (s_q.st == S_OPER2 && s_q.op == OP_DBL_LD
        |=> s_q.b == $past(rdat) && s_q.a == $past(s_q.a))
        else $error("double load word order wrong");
    dbl_st_second_a: assert property (s_q.st == S_OPER && s_q.op == OP_DBL_ST
        |=> s_q.st == S_OPER2 && s_q.wdata == s_q.b &&
            s_q.addr == $past(s_q.addr) + 16'h0001)
        else $error("double store second word wrong");
    rel_addr_a: assert property (s_q.st == S_FETCH && dec.op == OP_ST_A &&
        dec.form == FORM_SHORT && dec.mode[1:0] == 2'h3 |=>
        s_q.addr == $past(s_q.p + {{6{rdat[SFLD_HI]}}, rdat[SFLD_HI:0]}))
        else $error("relative address wrong");
endmodule
`default_nettype wire

// file: sim/eals_mem_model.sv
/*
  Core memory model for the eals_core bench: 4096 words, read word driven
  while mem_rd stands. Assumes the bench preloads mem through the hierarchy.
*/
`timescale 1ns/100ps
`default_nettype none
module eals_mem_model (
    input  wire logic        mclk,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output var  logic [15:0] mem_rdata
);
    logic [15:0] mem [0:4095];
    logic [15:0] last_q;
    initial last_q = 16'h0000;
    // high address bits ignored: an absent bank aliases real data here,
    // so only the block's own masking can give a zero word
    always @(posedge mclk) begin
        if (mem_wr)
            mem[mem_addr[11:0]] <= mem_wdata;
        if (mem_rd)
            last_q <= mem[mem_addr[11:0]];
    end
    // the core decodes in the cycle its strobe stands, so the word must
    // be there then; idle bus shows the inverse of the last word
    always_comb mem_rdata = mem_rd ? mem[mem_addr[11:0]] : ~last_q;
endmodule
`default_nettype wire

// file: sim/tb_eals_core.sv
/*
  Self-checking bench for eals_core: each test task loads a program, restarts
  the core from reset and checks some of registers, memory and io pulses.
  Assumes eals_mem_model as the memory and a zero word acting as no-op.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_eals_core;
    logic        mclk;
    logic        rst_b;
    logic [4:0]  mem_banks;
    logic [15:0] mem_rdata;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] io_data;
    logic        mem_rd;
    logic        mem_wr;
    logic        io_stb;
    logic [2:0]  io_dev;
    logic [15:0] reg_a;
    logic [15:0] reg_b;
    logic [15:0] reg_x;
    logic [15:0] reg_p;
    int          failures;
    int          tests_run;
    int          io_n;
    logic [15:0] io_d [0:3];
    logic [15:0] io_v [0:3];

    eals_core eals_core_inst (.mclk, .rst_b, .mem_rdata, .mem_banks,
        .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .io_stb, .io_dev,
        .io_data, .reg_a, .reg_b, .reg_x, .reg_p);
    eals_mem_model eals_mem_model_inst (.mclk, .mem_rd, .mem_wr,
        .mem_addr, .mem_wdata, .mem_rdata);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (rst_b === 1'b0) begin
            io_n <= 0;
        end else if (io_stb === 1'b1) begin
            io_d[io_n[1:0]] <= io_data;
            io_v[io_n[1:0]] <= {13'h0000, io_dev};
            io_n <= io_n + 1;
        end
    end

    task automatic chk(input logic [15:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic put(input int a, input logic [15:0] d);
        eals_mem_model_inst.mem[a] = d;
    endtask
    function automatic logic [15:0] rd(input int a);
        return eals_mem_model_inst.mem[a];
    endfunction
    task automatic start(input logic [4:0] banks);
        @(negedge mclk);
        rst_b = 1'b0;
        mem_banks = banks;
        for (int i = 0; i < 4096; i++)
            put(i, 16'h0000);
    endtask
    // program area stays below 0x40 within the run, data sits from 0x80
    task automatic run();
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        repeat (40) @(negedge mclk);
    endtask

    task automatic short_modes();
        start(5'h10);
        put(0, 16'h3080); put(1, 16'h1481); put(2, 16'h2882);
        put(3, 16'h4ffe); put(4, 16'h6086); put(5, 16'h5487);
        put('h80, 16'h0003); put('h84, 16'h1111);
        put('h82, 16'h0085); put('h85, 16'h2222);
        run();
        chk(reg_x, 16'h0003, "short direct");
        chk(reg_a, 16'h1111, "short indexed");
        chk(reg_b, 16'h2222, "short indirect");
        chk(rd(2), 16'h1111, "short relative");
        chk(rd('h86), 16'h0003, "store x");
        chk(rd('h8a), 16'h2222, "store b");
    endtask

    task automatic long_modes();
        start(5'h10);
        put(0, 16'h00c0); put(1, 16'h0004); put(2, 16'h0045);
        put(3, 16'h0090); put(4, 16'h0087); put(5, 16'h0090);
        put(6, 16'h0243); put(7, 16'h0093); put(8, 16'h0106);
        put(9, 16'h0060); put(10, 16'h0184); put(11, 16'h0001);
        put(12, 16'h0082); put(13, 16'h0098);
        put('h90, 16'h8091); put('h91, 16'h00a0); put('ha4, 16'h5555);
        put('h96, 16'h6666); put('h97, 16'h0050); put('h98, 16'h00b0);
        run();
        chk(rd('hb0), 16'h5555, "multi-level post-x");
        chk(rd('h556), 16'h0050, "field plus a");
        chk(reg_b, 16'h5555, "long indirect");
        chk(reg_x, 16'h0050, "lea pre-indexed");
        chk(reg_a, 16'h5555, "long immediate x");
    endtask

    task automatic relative_long();
        start(5'h10);
        put(0, 16'h0087); put(1, 16'h0090); put('h92, 16'h6666);
        run();
        chk(reg_b, 16'h6666, "long p relative");
    endtask

    task automatic double_words();
        start(5'h01);
        put(0, 16'h01c1); put(1, 16'h0088); put(2, 16'h0201);
        put(3, 16'h008c); put(4, 16'h00c0); put(5, 16'h0003);
        put(6, 16'h00c1); put(7, 16'h1000);
        put(8, 16'h0101); put(9, 16'h1001);
        put('h88, 16'h1234); put('h89, 16'h0567);
        run();
        chk(reg_a, 16'h1234, "double load hi");
        chk(reg_b, 16'h0567, "double load lo");
        chk(rd('h8c), 16'h1234, "double store hi");
        chk(rd('h8d), 16'h0567, "double store lo");
        chk(reg_x, 16'h0000, "absent read");
        chk(rd(1), 16'h0088, "absent write");
    endtask

    task automatic io_modes();
        start(5'h10);
        put(0, 16'h1080); put(1, 16'h02a9); put(2, 16'h0290);
        put(3, 16'h0777); put('h80, 16'h00aa);
        run();
        chk(io_n[15:0], 16'h0002, "io count");
        chk(io_d[0], 16'h00aa, "io reg a");
        chk(io_v[0], 16'h0005, "io dev");
        chk(io_d[1], 16'h0777, "io next word");
        chk(io_v[1], 16'h0002, "io dev 2");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // five short programs need about 220 cycles; 3000 is ample margin
    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        mem_banks = 5'h10;
        failures = 0;
        tests_run = 0;
        short_modes();
        long_modes();
        relative_long();
        double_words();
        io_modes();
        summarize();
    end
endmodule
`default_nettype wire
